// [rlc_pkg.sv]
`default_nettype none
package rlc_pkg;
    // =====================================================
    // widths
    localparam int DATA_W = 8;                    // operand byte
    localparam int ADDR_W = 12;                   // data space address
    localparam int BANK_W = 4;                    // bank number width
    localparam int OPC_W  = 6;                    // opcode field width

    // =====================================================
    // encoding and bit positions
    localparam logic [OPC_W-1:0] OPC_ROTL_CARRY = 6'h0d; // 0011 01da
    localparam int               MSB_BIT        = 7;     // bit leaving into carry
    localparam int               LSB_BIT        = 0;     // bit fed from carry

    // =====================================================
    // access bank layout
    localparam logic [DATA_W-1:0] ACC_SPLIT   = 8'h60;   // first byte of the upper half
    localparam logic [DATA_W-1:0] IDX_LIMIT   = 8'h5f;   // last indexed offset (95)
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;    // lower half lives in bank 0
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;    // upper half lives in the top bank

    // =====================================================
    // reset values
    localparam logic [DATA_W-1:0] W_RST    = 8'h00;      // working register
    localparam logic              FLAG_RST = 1'b0;       // every status flag

    // =====================================================
    // carrier types
    typedef struct packed {
        logic [OPC_W-1:0]  opc;                   // operation code
        logic              dest;                  // 1: back to operand, 0: working register
        logic              acc;                   // 1: banked, 0: access bank
        logic [DATA_W-1:0] f;                     // file address byte
    } rlc_insn_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                  // resolved data address
        logic [DATA_W-1:0] wdata;                 // byte to write
        logic              re;                    // read strobe
        logic              we;                    // write strobe
    } rlc_file_req_t;

    typedef struct packed {
        logic neg;                                // result bit 7
        logic zero;                               // result is zero
        logic carry;                              // bit shifted out
    } rlc_flags_t;
endpackage : rlc_pkg
`default_nettype wire

// [rlc_exec.sv]
`timescale 1ns/10ps
`default_nettype none
module rlc_exec
    import rlc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 insn_valid,
    output logic                      insn_ready,
    input  wire rlc_insn_t            insn_word,
    input  wire logic                 ext_set_en,
    input  wire logic [BANK_W-1:0]    bank_number_register,
    input  wire logic [ADDR_W-1:0]    index_base,
    input  wire logic [DATA_W-1:0]    file_rdata,
    output rlc_file_req_t             file_req,
    output logic [DATA_W-1:0]         w_out,
    output rlc_flags_t                flags_out,
    output logic                      done,
    output logic                      bad_op
);

    // the block runs one instruction at a time: every clock edge is one quarter
    // phase, so a whole instruction cycle is four edges plus one idle edge in
    // which the next word is taken. the register file itself sits outside; this
    // block only asks for one byte in q2 and hands one byte back in q4.

    // =====================================================
    // quarter phases of the instruction cycle
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } rlc_phase_t;

    // pipeline registers; opnd_r to flags_r each written in one quarter, phase_r, req_r and the pulses in more
    rlc_phase_t        phase_r;                   // current quarter
    rlc_phase_t        phase_nxt;                 // next quarter
    rlc_insn_t         insn_r;                    // instruction held for the cycle
    logic [ADDR_W-1:0] addr_nxt;                  // combinational address
    logic [DATA_W-1:0] opnd_r;                    // operand read in Q2
    logic [DATA_W-1:0] res_r;                     // rotated result from Q3
    logic              cout_r;                    // carry out from Q3
    logic              legal_r;                   // opcode matched in Q1
    logic [DATA_W-1:0] w_r;                       // working register
    rlc_flags_t        flags_r;                   // status flags
    rlc_file_req_t     req_r;                     // registered file request
    logic              done_r;                    // end of cycle pulse
    logic              bad_r;                     // unknown opcode pulse

    // a new instruction is only taken between cycles
    assign insn_ready = (phase_r == PH_IDLE);
    assign file_req   = req_r;
    assign w_out      = w_r;
    assign flags_out  = flags_r;
    assign done       = done_r;
    assign bad_op     = bad_r;

    // =====================================================
    // phase sequencer
    // a fixed sequence with no wait states keeps the latency constant, at the
    // cost of a dead idle quarter between back to back instructions
    always_comb begin
        case (phase_r)
            PH_IDLE: begin
                // idle until an instruction is offered
                phase_nxt = insn_valid ? PH_Q1 : PH_IDLE;
            end
            PH_Q1: begin
                phase_nxt = PH_Q2;
            end
            PH_Q2: begin
                phase_nxt = PH_Q3;
            end
            PH_Q3: begin
                phase_nxt = PH_Q4;
            end
            PH_Q4: begin
                // back to back: the next word may be taken right after Q4
                phase_nxt = PH_IDLE;
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
    end

    // strictly four quarters per instruction, no stalls
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_r <= PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // instruction capture on acceptance
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            insn_r <= '0;
        end else if (insn_ready && insn_valid) begin
            insn_r <= insn_word;
        end
    end

    // =====================================================
    // operand address resolution
    // priority: banked first, then the indexed window, then the two access halves.
    // the indexed window only exists with the extended set on; without it the
    // same low bytes fall back to the lower access half as plain addresses.
    // bank, extended set switch and index base count only at the q1 edge;
    // the word itself is the captured copy, so the caller may move on early.
    always_comb begin
        addr_nxt = '0;
        if (insn_r.acc) begin
            // banked access: bank number on top of the byte
            addr_nxt = {bank_number_register, insn_r.f};
        end else if (ext_set_en && (insn_r.f <= IDX_LIMIT)) begin
            // indexed literal offset off the index base; wraps inside data space
            addr_nxt = ADDR_W'(index_base + {{(ADDR_W-DATA_W){1'b0}}, insn_r.f});
        end else if (insn_r.f < ACC_SPLIT) begin
            // lower half of the access bank
            addr_nxt = {ACC_LO_BANK, insn_r.f};
        end else begin
            // upper half maps onto the special function area
            addr_nxt = {ACC_HI_BANK, insn_r.f};
        end
    end

    // q1: decode and check the opcode
    // the resolved address goes straight into the file request below
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            legal_r <= 1'b0;
        end else if (phase_r == PH_Q1) begin
            legal_r <= (insn_r.opc == OPC_ROTL_CARRY);
        end
    end

    // =====================================================
    // file request: read in q2, write in q4
    // both strobes are single quarter pulses; the address is not cleared
    // afterwards so the file sees a stable address across the write as well.
    // hazard: an unknown opcode must not reach the file at all, hence the
    // opcode test on the read and legal_r on the write.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_r <= '0;
        end else begin
            req_r.re <= 1'b0;
            req_r.we <= 1'b0;
            if (phase_r == PH_Q1) begin
                // strobe stands through q2, address already resolved
                req_r.addr <= addr_nxt;
                req_r.re   <= (insn_r.opc == OPC_ROTL_CARRY);
            end else if (phase_r == PH_Q3 && legal_r && insn_r.dest) begin
                // result goes back to the operand location
                req_r.wdata <= {opnd_r[MSB_BIT-1:LSB_BIT], flags_r.carry};
                req_r.we    <= 1'b1;
            end
        end
    end

    // q2: the file answers within the same quarter, taken at its end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opnd_r <= '0;
        end else if (phase_r == PH_Q2) begin
            opnd_r <= file_rdata;
        end
    end

    // =====================================================
    // q3: rotate through carry
    // the carry used for bit 0 is the flag as it stands before q4, so a chain
    // of rotates moves one bit per instruction through the carry
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            res_r  <= '0;
            cout_r <= FLAG_RST;
        end else if (phase_r == PH_Q3) begin
            res_r  <= {opnd_r[MSB_BIT-1:LSB_BIT], flags_r.carry};
            cout_r <= opnd_r[MSB_BIT];
        end
    end

    // =====================================================
    // q4: working register, only when dest is zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            w_r <= W_RST;
        end else if (phase_r == PH_Q4 && legal_r && !insn_r.dest) begin
            w_r <= res_r; // operand location left untouched
        end
    end

    // q4: status flags follow the result
    // an unknown opcode leaves all flags as they were
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_r <= '{neg: FLAG_RST, zero: FLAG_RST, carry: FLAG_RST};
        end else if (phase_r == PH_Q4 && legal_r) begin
            flags_r.carry <= cout_r;
            flags_r.neg   <= res_r[MSB_BIT];
            flags_r.zero  <= (res_r == '0);
        end
    end

    // =====================================================
    // completion pulses, one cycle after q4
    // an unknown opcode still burns the whole cycle so timing stays fixed
    // done and bad_op never stand longer than one cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            bad_r  <= 1'b0;
        end else begin
            done_r <= (phase_r == PH_Q4);
            bad_r  <= (phase_r == PH_Q4) && !legal_r;
        end
    end

endmodule : rlc_exec
`default_nettype wire

// [rlc_exec_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module rlc_exec_chk
    import rlc_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              insn_valid,
    input wire logic              insn_ready,
    input wire rlc_insn_t         insn_word,
    input wire logic              ext_set_en,
    input wire logic [BANK_W-1:0] bank_number_register,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire rlc_file_req_t     file_req,
    input wire logic [DATA_W-1:0] w_out,
    input wire rlc_flags_t        flags_out,
    input wire logic              done,
    input wire logic              bad_op
);
    // =====================================================
    // phase and data relations, one clock domain
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RE_ONE: assert property (file_req.re |=> !file_req.re) else $error("read strobe too long");
    AST_WE_SPACING: assert property (file_req.we |-> $past(file_req.re, 2)) else $error("write not two after read");
    AST_WE_DONE: assert property (file_req.we |=> done && !bad_op) else $error("done missing after write");
    // operand is taken in q2, three cycles before the done cycle
    property p_wdata_rot;
        file_req.we |-> file_req.wdata == {$past(file_rdata[6:0], 2), flags_out.carry};
    endproperty
    property p_carry_out;
        file_req.we |=> flags_out.carry == $past(file_rdata[7], 3);
    endproperty
    property p_nz;
        file_req.we |=> flags_out.neg == $past(file_req.wdata[7]) &&
            flags_out.zero == ($past(file_req.wdata) == 8'h00);
    endproperty
    property p_w_dest0;
        done && !bad_op && !insn_word.dest |-> w_out == {$past(file_rdata[6:0], 3), $past(flags_out.carry)};
    endproperty
    property p_banked;
        file_req.re && insn_word.acc |-> file_req.addr == {bank_number_register, insn_word.f};
    endproperty
    property p_indexed;
        file_req.re && !insn_word.acc && ext_set_en && insn_word.f <= IDX_LIMIT |->
            file_req.addr == index_base + ADDR_W'(insn_word.f);
    endproperty
    property p_access;
        file_req.re && !insn_word.acc && !(ext_set_en && insn_word.f <= IDX_LIMIT) |->
            file_req.addr == {(insn_word.f >= ACC_SPLIT) ? ACC_HI_BANK : ACC_LO_BANK, insn_word.f};
    endproperty
    property p_bad_quiet;
        bad_op |-> done && !$past(file_req.we) && !$past(file_req.re, 3) && $stable(w_out) && $stable(flags_out);
    endproperty
    AST_WDATA_ROT: assert property (p_wdata_rot) else $error("rotated byte wrong");
    AST_CARRY_OUT: assert property (p_carry_out) else $error("carry not old bit 7");
    AST_NZ: assert property (p_nz) else $error("sign or zero flag wrong");
    AST_W_DEST0: assert property (p_w_dest0) else $error("working reg wrong");
    AST_D0_NO_WRITE: assert property (done && !insn_word.dest |-> !$past(file_req.we)) else $error("dest zero wrote");
    AST_W_KEEP: assert property (done && insn_word.dest |-> $stable(w_out)) else $error("working reg moved");
    AST_BANKED: assert property (p_banked) else $error("banked address wrong");
    AST_INDEXED: assert property (p_indexed) else $error("indexed address wrong");
    AST_ACCESS: assert property (p_access) else $error("access bank address wrong");
    AST_BAD_QUIET: assert property (p_bad_quiet) else $error("refused op touched state");
    // main scenarios reached
    cover property (file_req.we);
    cover property (done && !insn_word.dest);
    cover property (bad_op);
    cover property (file_req.re && !insn_word.acc && ext_set_en && insn_word.f <= IDX_LIMIT);
endmodule : rlc_exec_chk
`default_nettype wire

// [rotate_left_carry_exec_test.sv]
`timescale 1ns/10ps
`default_nettype none
module rotate_left_carry_exec_test;
    import rlc_pkg::*;
    // =====================================================
    // stimulus and observed signals
    logic ref_clk = 0, rst_n = 0, insn_valid = 0, ext_set_en = 0, insn_ready, done, bad_op;
    rlc_insn_t insn_word = '0;
    logic [BANK_W-1:0] bank_number_register = 4'h5;
    logic [ADDR_W-1:0] index_base = 12'hff0;  // near the top so the offset wraps
    logic [DATA_W-1:0] file_rdata = 8'h00, w_out, c_w = 8'h00;
    logic c_c = 1'b0;                          // carry the bench expects the core to hold
    logic [2:0] c_f = 3'h0;                    // expected neg, zero, carry
    rlc_file_req_t file_req;
    rlc_flags_t flags_out;
    int err_count = 0, tests_run = 0;
    always #20 ref_clk = ~ref_clk;             // 25 MHz
    rlc_exec uut (.ref_clk(ref_clk), .rst_n(rst_n), .insn_valid(insn_valid), .insn_ready(insn_ready),
        .insn_word(insn_word), .ext_set_en(ext_set_en), .bank_number_register(bank_number_register),
        .index_base(index_base), .file_rdata(file_rdata), .file_req(file_req), .w_out(w_out),
        .flags_out(flags_out), .done(done), .bad_op(bad_op));
    // =====================================================
    // reporting
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one instruction, expectations derived from the bench's own carry and W copies
    task automatic run_op(input logic [5:0] opc, input logic d, a, input logic [7:0] f, rd, input logic ext,
                          input logic [11:0] ea);
        logic [7:0] res;
        logic sr, sw, ok;
        int n;
        res = {rd[6:0], c_c};
        ok = (opc == OPC_ROTL_CARRY);
        sr = 0;
        sw = 0;
        n = 0;
        insn_word = '{opc, d, a, f};
        ext_set_en = ext;
        file_rdata = rd;
        insn_valid = 1;
        @(negedge ref_clk);
        insn_valid = 0;
        while (done !== 1'b1) begin
            chk("busy", 12'h000, 12'(insn_ready));
            if (file_req.re === 1'b1) begin
                sr = 1;
                chk("addr", ea, file_req.addr);
            end
            if (file_req.we === 1'b1) begin
                sw = 1;
                chk("wdata", 12'(res), 12'(file_req.wdata));
            end
            n++;
            if (n > 8) begin
                err_count++;
                end_sim();
            end
            @(negedge ref_clk);
        end
        chk("quarters", 12'h004, 12'(n));
        chk("ready_done", 12'h001, 12'(insn_ready));
        chk("bad_op", 12'(!ok), 12'(bad_op));
        chk("read", 12'(ok), 12'(sr));
        chk("write", 12'(ok & d), 12'(sw));
        if (ok) begin
            if (!d) c_w = res;
            c_c = rd[7];
            c_f = {res[7], res == 8'h00, rd[7]};
        end
        chk("w_out", 12'(c_w), 12'(w_out));
        chk("flags", 12'(c_f), 12'(flags_out));
        @(negedge ref_clk);
        chk("done_pulse", 12'h000, 12'({done, bad_op}));
    endtask : run_op
    // =====================================================
    // scenarios
    task automatic s_to_w();
        run_op(OPC_ROTL_CARRY, 0, 0, 8'h20, 8'he6, 0, 12'h020);
        chk("w_win", 12'h0cc, 12'(w_out));
    endtask : s_to_w
    task automatic s_banked_back();
        run_op(OPC_ROTL_CARRY, 1, 1, 8'h34, 8'h00, 0, 12'h534);
        run_op(OPC_ROTL_CARRY, 1, 1, 8'h05, 8'h00, 1, 12'h505);
    endtask : s_banked_back
    task automatic s_access_high();
        run_op(OPC_ROTL_CARRY, 1, 0, 8'h60, 8'h80, 1, 12'hf60);
        run_op(OPC_ROTL_CARRY, 0, 0, 8'hff, 8'h7f, 0, 12'hfff);
    endtask : s_access_high
    task automatic s_indexed();
        run_op(OPC_ROTL_CARRY, 1, 0, 8'h5f, 8'h81, 1, 12'h04f);
        run_op(OPC_ROTL_CARRY, 0, 0, 8'h00, 8'h55, 1, 12'hff0);
    endtask : s_indexed
    task automatic s_bad_opcode();
        run_op(6'h0c, 1, 0, 8'h10, 8'hff, 0, 12'h010);
        run_op(OPC_ROTL_CARRY, 0, 0, 8'h10, 8'h01, 0, 12'h010);
    endtask : s_bad_opcode
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1;
        chk("ready", 12'h001, 12'(insn_ready));
        chk("idle", 12'h000, 12'({w_out, flags_out, done}));
        chk("strobes", 12'h000, 12'({file_req.re, file_req.we, bad_op}));
        s_to_w();
        s_banked_back();
        s_access_high();
        s_indexed();
        s_bad_opcode();
        end_sim();
    end
endmodule : rotate_left_carry_exec_test
bind rlc_exec rlc_exec_chk u_chk (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .insn_valid           (insn_valid),
    .insn_ready           (insn_ready),
    .insn_word            (insn_word),
    .ext_set_en           (ext_set_en),
    .bank_number_register (bank_number_register),
    .index_base           (index_base),
    .file_rdata           (file_rdata),
    .file_req             (file_req),
    .w_out                (w_out),
    .flags_out            (flags_out),
    .done                 (done),
    .bad_op               (bad_op)
);
`default_nettype wire
